// ==== hw/sample_pair_buf.v ====
/*
 * Two-entry buffer with valid/ready on both sides for the mixed sample
 * stream. Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sample_pair_buf #(
	parameter W = 16
) (
	input wire ref_clk_i,
	input wire reset_n_i,
	input wire in_valid_i,
	output wire in_ready_o,
	input wire [W-1:0] in_data_i,
	output wire out_valid_o,
	input wire out_ready_i,
	output wire [W-1:0] out_data_o
);
	reg [W-1:0] slot0;
	reg [W-1:0] slot1;
	reg [1:0] fill;
	wire push = in_valid_i && in_ready_o;
	wire pop = out_valid_o && out_ready_i;

	// ready only while a slot is free, so a stalled reader pushes back
	assign in_ready_o = (fill != 2'h2);
	assign out_valid_o = (fill != 2'h0);
	assign out_data_o = slot0;

	// slot0 is always the head; slot1 shifts down on a pop
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			slot0 <= {W{1'b0}};
			slot1 <= {W{1'b0}};
			fill <= 2'h0;
		end else begin
			if (pop) begin
				slot0 <= (fill == 2'h2) ? slot1 : in_data_i;
			end
			if (push) begin
				if (fill == 2'h0 || (fill == 2'h1 && pop)) begin
					slot0 <= in_data_i;
				end else begin
					slot1 <= in_data_i;
				end
			end
			if (push && !pop) begin
				fill <= fill + 2'h1;
			end else if (pop && !push) begin
				fill <= fill - 2'h1;
			end
		end
	end
endmodule

`default_nettype wire

// ==== hw/voice_ctrl_defines.vh ====
/*
 * Shared constants of the voice playback command controller: command
 * encodings, external ROM layout, power states and timing figures.
 * Assumes inclusion by bare name from the design files under hw/.
 */
`ifndef VOICE_CTRL_DEFINES_VH
`define VOICE_CTRL_DEFINES_VH

// command bytes and first-byte opcode nibbles
`define CMD_POWER_UP 8'h00
`define CMD_POWER_DOWN 8'h20
`define CMD_ANALOG_MODE 8'h04
`define OPC_PLAY 4'h4
`define OPC_STOP 4'h6
`define OPC_CHAN_VOLUME 4'hA

// analog mode second byte: speaker enable bit position
`define ANALOG_MODE_CMD_SPEN_BIT 1

// external ROM layout
`define ROM_CTRL_BASE 24'h000000
`define ROM_TEST_BASE 24'h002000
`define ROM_TEST_LAST 24'h00205F
`define ROM_WAVE_BASE 24'h002060
`define ROM_TOP 24'hFFFFFF
`define CTRL_ENTRY_SHIFT 3
`define PHRASE_COUNT 1024

// sample algorithms
`define ALG_ADPCM4 2'h0
`define ALG_NLPCM8 2'h1
`define ALG_PCM8 2'h2
`define ALG_PCM16 2'h3

// header kinds delivered by the ROM reader
`define HDR_PHRASE 2'h0
`define HDR_GAP 2'h1
`define HDR_END 2'h2

// power states
`define PWR_DOWN 2'h0
`define PWR_WAIT 2'h1
`define PWR_GODOWN 2'h2

// reset values
`define VOL_RESET 5'h00
`define ANALOG_MODE_CMD_RESET 8'h40
`define ADPCM_STEP_RESET 12'h010

// timing
`define CLK_PERIOD_NS 10
`define T_CMD_NS 10000
`define T_CMD_CYC (`T_CMD_NS / `CLK_PERIOD_NS)
`define T_MS_NS 1000000
`define T_MS_CYC (`T_MS_NS / `CLK_PERIOD_NS)
`define GAP_MIN_MS 11'd20
`define GAP_MAX_MS 11'd1024

`endif

// ==== hw/voice_playback_power_command_control.v ====
/*
 * Command interpreter, power state, four playback channels and mixer of a
 * voice playback device. Assumes a ROM reader on the same clock that
 * answers phrase and sequencing requests, and byte commands from host logic.
 */
`timescale 1ns/1ps
`default_nettype none
`include "voice_ctrl_defines.vh"

module voice_playback_power_command_control #(
	parameter MS_CYCLES = `T_MS_CYC,
	parameter CMD_CYCLES = `T_CMD_CYC
) (
	input wire ref_clk_i,
	input wire reset_n_i,
	input wire cmd_valid_i,
	output wire cmd_ready_o,
	input wire [7:0] cmd_byte_i,
	output wire cmd_busy_pin_n_o,
	output wire [3:0] cmd_ready_n_o,
	output wire [3:0] chan_busy_n_o,
	output wire [3:0] phrase_req_o,
	output wire [95:0] phrase_entry_addr_o,
	output wire [3:0] seq_req_o,
	input wire hdr_valid_i,
	input wire [1:0] hdr_chan_i,
	input wire [1:0] hdr_kind_i,
	input wire [1:0] hdr_algo_i,
	input wire [23:0] hdr_start_i,
	input wire [23:0] hdr_end_i,
	input wire hdr_seq_i,
	input wire [10:0] hdr_gap_ms_i,
	output wire [3:0] data_req_o,
	input wire [3:0] data_valid_i,
	input wire [63:0] data_i,
	input wire sample_tick_i,
	output wire mix_valid_o,
	input wire mix_ready_i,
	output wire [15:0] mix_data_o,
	output reg speaker_amp_en_o,
	output reg speaker_out_neg_oe_o,
	output reg speaker_out_pos_gnd_o,
	output reg signal_ground_ref_gnd_o,
	output reg internal_regulator_out_gnd_o,
	output wire [1:0] power_state_o
);
	localparam P_NONE = 2'h0;
	localparam P_ANALOG_MODE_CMD = 2'h1;
	localparam P_PLAY = 2'h2;
	localparam P_CHANNEL_VOLUME_CMD = 2'h3;
	localparam CH_IDLE = 3'h0;
	localparam CH_FETCH = 3'h1;
	localparam CH_PLAY = 3'h2;
	localparam CH_SEQ = 3'h3;
	localparam CH_GAP = 3'h4;

	// saturate an 18-bit signed value to 16 bits
	function [15:0] sat16;
		input signed [17:0] v;
		begin
			if (v > 18'sh07FFF) begin
				sat16 = 16'h7FFF;
			end else if (v < -18'sh08000) begin
				sat16 = 16'h8000;
			end else begin
				sat16 = v[15:0];
			end
		end
	endfunction

	// stateless decoders; nonlinear codes are sign, 3-bit exponent, 4-bit mantissa
	function [15:0] decode_pcm;
		input [1:0] alg;
		input [15:0] raw;
		reg [15:0] mag;
		begin
			mag = {8'h00, 4'h1, raw[3:0]} << raw[6:4];
			mag = mag << 3;
			case (alg)
				`ALG_NLPCM8: decode_pcm = raw[7] ? (16'h0000 - mag) : mag;
				`ALG_PCM8: decode_pcm = {raw[7:0], 8'h00};
				`ALG_PCM16: decode_pcm = raw;
				default: decode_pcm = 16'h0000;
			endcase
		end
	endfunction

	// phrase control entry address of a phrase number
	function [23:0] entry_addr;
		input [9:0] phrase;
		begin
			entry_addr = `ROM_CTRL_BASE + ({14'h0000, phrase} << `CTRL_ENTRY_SHIFT);
		end
	endfunction

	reg [1:0] pwr;
	reg [15:0] proc_cnt;
	reg [1:0] pend;
	reg [5:0] pend_arg;
	reg [7:0] analog_mode_cmd;
	reg [19:0] vols;
	reg [3:0] play_go;
	reg [9:0] play_phr;
	reg [3:0] stop_go;
	reg tick_pend;
	wire [2:0] st_all [0:3];
	wire [3:0] ch_active;
	wire [3:0] ch_fetch;
	wire proc = (proc_cnt != 16'h0000);
	wire take = cmd_valid_i && cmd_ready_o;
	wire [3:0] opc = cmd_byte_i[7:4];

	assign cmd_ready_o = !proc;
	assign cmd_busy_pin_n_o = !proc;
	assign power_state_o = pwr;
	assign cmd_ready_n_o = ~({4{proc}} | ch_fetch);
	assign chan_busy_n_o = ~({4{proc}} | ch_active);

	// command interpreter and power state; settings clear on power-down
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pwr <= `PWR_DOWN;
			proc_cnt <= 16'h0000;
			pend <= P_NONE;
			pend_arg <= 6'h00;
			analog_mode_cmd <= `ANALOG_MODE_CMD_RESET;
			vols <= {4{`VOL_RESET}};
			play_go <= 4'h0;
			play_phr <= 10'h000;
			stop_go <= 4'h0;
		end else begin
			play_go <= 4'h0;
			stop_go <= 4'h0;
			if (take) begin
				proc_cnt <= CMD_CYCLES[15:0];
			end else if (proc) begin
				proc_cnt <= proc_cnt - 16'h0001;
			end
			// busy pin rises at the end of power-down processing
			if (pwr == `PWR_GODOWN && proc_cnt == 16'h0001) begin
				pwr <= `PWR_DOWN;
				// settings clear only now, so the amplifier runs through the interval
				analog_mode_cmd <= `ANALOG_MODE_CMD_RESET;
				vols <= {4{`VOL_RESET}};
			end
			if (take && pend != P_NONE) begin
				pend <= P_NONE;
				case (pend)
					P_ANALOG_MODE_CMD: analog_mode_cmd <= cmd_byte_i;
					P_PLAY: begin
						play_go <= 4'h1 << pend_arg[1:0];
						play_phr <= {pend_arg[3:2], cmd_byte_i};
					end
					P_CHANNEL_VOLUME_CMD: begin
						if (pend_arg[0]) vols[4:0] <= cmd_byte_i[4:0];
						if (pend_arg[1]) vols[9:5] <= cmd_byte_i[4:0];
						if (pend_arg[2]) vols[14:10] <= cmd_byte_i[4:0];
						if (pend_arg[3]) vols[19:15] <= cmd_byte_i[4:0];
					end
					default: pend <= P_NONE;
				endcase
			end else if (take && pwr == `PWR_DOWN) begin
				// only the power-up byte means anything while powered down
				if (cmd_byte_i == `CMD_POWER_UP) begin
					pwr <= `PWR_WAIT;
				end
			end else if (take && pwr == `PWR_WAIT) begin
				if (cmd_byte_i == `CMD_POWER_DOWN) begin
					if (ch_active == 4'h0 && ch_fetch == 4'h0) begin
						pwr <= `PWR_GODOWN;
					end
				end else if (cmd_byte_i == `CMD_ANALOG_MODE) begin
					if (ch_active == 4'h0) begin
						pend <= P_ANALOG_MODE_CMD;
					end
				end else if (opc == `OPC_PLAY) begin
					pend <= P_PLAY;
					pend_arg <= cmd_byte_i[5:0];
				end else if (opc == `OPC_STOP) begin
					stop_go <= cmd_byte_i[3:0];
				end else if (opc == `OPC_CHAN_VOLUME) begin
					pend <= P_CHANNEL_VOLUME_CMD;
					pend_arg <= {2'h0, cmd_byte_i[3:0]};
				end
			end
		end
	end

	// analog pins: amplifier only through the analog mode setting
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			speaker_amp_en_o <= 1'b0;
			speaker_out_neg_oe_o <= 1'b0;
			speaker_out_pos_gnd_o <= 1'b1;
			signal_ground_ref_gnd_o <= 1'b1;
			internal_regulator_out_gnd_o <= 1'b1;
		end else begin
			speaker_amp_en_o <= (pwr != `PWR_DOWN) && analog_mode_cmd[`ANALOG_MODE_CMD_SPEN_BIT];
			speaker_out_neg_oe_o <= (pwr != `PWR_DOWN) && analog_mode_cmd[`ANALOG_MODE_CMD_SPEN_BIT];
			speaker_out_pos_gnd_o <= (pwr == `PWR_DOWN);
			signal_ground_ref_gnd_o <= (pwr == `PWR_DOWN);
			internal_regulator_out_gnd_o <= (pwr == `PWR_DOWN);
		end
	end

	genvar g;
	wire [87:0] scaled;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			localparam [1:0] CH = g;
			reg [2:0] st;
			reg [1:0] algo;
			reg seq;
			reg [24:0] pos;
			reg [24:0] last;
			reg [15:0] smp;
			reg [11:0] step;
			reg [10:0] gap_ms;
			reg [31:0] ms_cnt;
			reg [23:0] eaddr;
			wire hit = hdr_valid_i && (hdr_chan_i == CH);
			wire [15:0] raw = data_i[16*g +: 16];
			// a header is usable only if its samples lie in the waveform region
			wire hdr_ok = (hdr_start_i >= `ROM_WAVE_BASE) && (hdr_end_i >= hdr_start_i);
			wire [24:0] inc = (algo == `ALG_PCM16) ? 25'h4 : (algo == `ALG_ADPCM4) ? 25'h1 : 25'h2;
			wire [24:0] next_pos = pos + inc;
			wire [2:0] mag = raw[2:0];
			wire [15:0] diff = ({4'h0, step} * {12'h000, mag, 1'b1}) >> 3;
			wire signed [17:0] adp_sum = raw[3] ? ($signed({{2{smp[15]}}, smp}) -
				$signed({2'b00, diff})) : ($signed({{2{smp[15]}}, smp}) + $signed({2'b00, diff}));
			wire signed [21:0] prod = $signed(smp) * $signed({1'b0, vols[5*g +: 5]});

			assign st_all[g] = st;
			assign ch_active[g] = (st != CH_IDLE) && (st != CH_FETCH);
			assign ch_fetch[g] = (st == CH_FETCH);
			assign phrase_req_o[g] = (st == CH_FETCH);
			assign seq_req_o[g] = (st == CH_SEQ);
			assign data_req_o[g] = (st == CH_PLAY);
			assign phrase_entry_addr_o[24*g +: 24] = eaddr;
			assign scaled[22*g +: 22] = (st == CH_PLAY) ? (prod >>> 5) : 22'sh000000;

			// channel sequencer: fetch header, play, follow sequencing list
			always @(posedge ref_clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					st <= CH_IDLE;
					algo <= `ALG_ADPCM4;
					seq <= 1'b0;
					pos <= 25'h0;
					last <= 25'h0;
					smp <= 16'h0000;
					step <= `ADPCM_STEP_RESET;
					gap_ms <= 11'h000;
					ms_cnt <= 32'h0;
					eaddr <= `ROM_CTRL_BASE;
				end else if (pwr == `PWR_DOWN || stop_go[g]) begin
					st <= CH_IDLE;
					smp <= 16'h0000;
				end else if (play_go[g]) begin
					st <= CH_FETCH;
					eaddr <= entry_addr(play_phr);
				end else begin
					case (st)
						CH_FETCH, CH_SEQ: begin
							if (hit && hdr_kind_i == `HDR_PHRASE) begin
								st <= hdr_ok ? CH_PLAY : CH_IDLE;
								algo <= hdr_algo_i;
								pos <= {hdr_start_i, 1'b0};
								last <= {hdr_end_i, 1'b1};
								smp <= 16'h0000;
								step <= `ADPCM_STEP_RESET;
								seq <= hdr_seq_i | (st == CH_SEQ);
							end else if (hit && st == CH_SEQ && hdr_kind_i == `HDR_GAP) begin
								st <= CH_GAP;
								ms_cnt <= 32'h0;
								gap_ms <= (hdr_gap_ms_i < `GAP_MIN_MS) ? `GAP_MIN_MS :
									(hdr_gap_ms_i > `GAP_MAX_MS) ? `GAP_MAX_MS : hdr_gap_ms_i;
							end else if (hit && st == CH_SEQ) begin
								st <= CH_IDLE;
							end
						end
						CH_PLAY: begin
							if (data_valid_i[g]) begin
								pos <= next_pos;
								if (algo == `ALG_ADPCM4) begin
									smp <= sat16(adp_sum);
									if (mag >= 3'h4) begin
										step <= (step >= 12'h400) ? 12'h7FF : {step[10:0], 1'b0};
									end else if (step > `ADPCM_STEP_RESET) begin
										step <= step - {3'h0, step[11:3]};
									end
								end else begin
									smp <= decode_pcm(algo, raw);
								end
								// the sequencing list is read only for phrases that asked or were reached through the list
								if (next_pos > last) begin
									st <= seq ? CH_SEQ : CH_IDLE;
								end
							end
						end
						CH_GAP: begin
							smp <= 16'h0000;
							if (ms_cnt == MS_CYCLES - 1) begin
								ms_cnt <= 32'h0;
								gap_ms <= gap_ms - 11'h001;
								if (gap_ms == 11'h001) begin
									st <= CH_SEQ;
								end
							end else begin
								ms_cnt <= ms_cnt + 32'h1;
							end
						end
						default: st <= CH_IDLE;
					endcase
				end
			end
		end
	endgenerate

	// mixer: one summed sample per tick, held while the buffer is full
	reg signed [23:0] mix_sum;
	reg [15:0] mix_word;
	wire buf_ready;
	wire mix_go = (sample_tick_i || tick_pend) && (pwr != `PWR_DOWN);
	always @* begin
		mix_sum = $signed({{2{scaled[21]}}, scaled[21:0]}) +
			$signed({{2{scaled[43]}}, scaled[43:22]}) +
			$signed({{2{scaled[65]}}, scaled[65:44]}) +
			$signed({{2{scaled[87]}}, scaled[87:66]});
		// clipping is left to the host's volume settings, the sum only saturates
		if (mix_sum > 24'sh007FFF) begin
			mix_word = 16'h7FFF;
		end else if (mix_sum < -24'sh008000) begin
			mix_word = 16'h8000;
		end else begin
			mix_word = mix_sum[15:0];
		end
	end

	// a tick that meets a full buffer waits rather than being dropped
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tick_pend <= 1'b0;
		end else begin
			tick_pend <= mix_go && !buf_ready;
		end
	end

	sample_pair_buf #(
		.W(16)
	) u_mix_buf (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.in_valid_i(mix_go),
		.in_ready_o(buf_ready),
		.in_data_i(mix_word),
		.out_valid_o(mix_valid_o),
		.out_ready_i(mix_ready_i),
		.out_data_o(mix_data_o)
	);
endmodule

`default_nettype wire

// ==== test/pwr_cmd_monitor.sv ====
/*
 * Concurrent checks on the command port, power state and pin controls.
 * Assumes one clock and an active-low asynchronous reset at the top ports.
 */
`timescale 1ns/1ps
`default_nettype none
module pwr_cmd_monitor #(
	parameter CMD_CYCLES = 1000
) (
	input wire ref_clk_i,
	input wire reset_n_i,
	input wire cmd_valid_i,
	input wire cmd_ready_o,
	input wire [7:0] cmd_byte_i,
	input wire cmd_busy_pin_n_o,
	input wire [3:0] cmd_ready_n_o,
	input wire [3:0] chan_busy_n_o,
	input wire mix_valid_o,
	input wire mix_ready_i,
	input wire [15:0] mix_data_o,
	input wire speaker_amp_en_o,
	input wire speaker_out_neg_oe_o,
	input wire speaker_out_pos_gnd_o,
	input wire signal_ground_ref_gnd_o,
	input wire internal_regulator_out_gnd_o,
	input wire [1:0] power_state_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	wire take = cmd_valid_i && cmd_ready_o;
	wire [2:0] gnds = {speaker_out_pos_gnd_o, signal_ground_ref_gnd_o,
		internal_regulator_out_gnd_o};
	reg [15:0] low_cnt;
	// length of the current processing interval, compared when ready returns
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			low_cnt <= 16'h0000;
		else if (cmd_ready_o)
			low_cnt <= 16'h0000;
		else
			low_cnt <= low_cnt + 16'h0001;
	end
	pup_enter_a: assert property (take && power_state_o == 2'h0 && cmd_byte_i == 8'h00
		|=> power_state_o == 2'h1) else $error("power-up not taken");
	down_ignore_a: assert property (take && power_state_o == 2'h0 && cmd_byte_i != 8'h00
		|=> power_state_o == 2'h0) else $error("byte acted on while down");
	wait_pup_a: assert property (take && power_state_o == 2'h1 && cmd_byte_i == 8'h00
		|=> power_state_o == 2'h1) else $error("power-up acted on while waiting");
	pdn_take_a: assert property (take && power_state_o == 2'h1 && cmd_byte_i == 8'h20
		&& &cmd_ready_n_o && &chan_busy_n_o |=> power_state_o == 2'h2)
		else $error("power-down not taken");
	proc_len_a: assert property ($rose(cmd_ready_o) |-> low_cnt == CMD_CYCLES)
		else $error("processing interval length wrong");
	pin_match_a: assert property (take |=> !cmd_busy_pin_n_o && !cmd_ready_o)
		else $error("busy pin not low after a take");
	proc_flags_a: assert property (!cmd_ready_o |-> cmd_ready_n_o == 4'h0
		&& chan_busy_n_o == 4'h0) else $error("channel flags high while processing");
	go_down_a: assert property ($past(power_state_o) == 2'h2 && $rose(cmd_busy_pin_n_o)
		|-> power_state_o == 2'h0) else $error("power-down not reached");
	down_pins_a: assert property ($past(power_state_o) == 2'h0 && power_state_o == 2'h0
		|-> gnds == 3'h7 && !speaker_amp_en_o && !speaker_out_neg_oe_o)
		else $error("analog pins wrong while down");
	amp_stay_a: assert property (take && power_state_o == 2'h0 && cmd_byte_i == 8'h00
		|=> !speaker_amp_en_o [*8]) else $error("amplifier on after power-up");
	hold_word_a: assert property (mix_valid_o && !mix_ready_i
		|=> mix_valid_o && $stable(mix_data_o)) else $error("stalled word changed");
endmodule
bind voice_playback_power_command_control pwr_cmd_monitor #(.CMD_CYCLES(CMD_CYCLES)) i_mon (
	.ref_clk_i, .reset_n_i, .cmd_valid_i, .cmd_ready_o, .cmd_byte_i, .cmd_busy_pin_n_o,
	.cmd_ready_n_o, .chan_busy_n_o, .mix_valid_o, .mix_ready_i, .mix_data_o,
	.speaker_amp_en_o, .speaker_out_neg_oe_o, .speaker_out_pos_gnd_o,
	.signal_ground_ref_gnd_o, .internal_regulator_out_gnd_o, .power_state_o);
`default_nettype wire

// ==== test/rom_reader_model.sv ====
/*
 * Behavioural ROM reader: answers phrase and sequencing requests with a header after a
 * fixed wait and feeds 16-bit words every other cycle. Same clock as the block.
 */
`timescale 1ns/1ps
`default_nettype none
module rom_reader_model (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic bad_start_i,
	input wire logic seq_mode_i,
	input wire logic [3:0] seq_req_i,
	input wire logic [3:0] phrase_req_i,
	input wire logic [3:0] data_req_i,
	output logic hdr_valid_o,
	output logic [1:0] hdr_chan_o,
	output logic [1:0] hdr_kind_o,
	output wire [1:0] hdr_algo_o,
	output wire [23:0] hdr_start_o,
	output wire [23:0] hdr_end_o,
	output wire hdr_seq_o,
	output wire [10:0] hdr_gap_ms_o,
	output logic [3:0] data_valid_o,
	output wire [63:0] data_o
);
	reg [1:0] wait_cnt;
	reg tog;
	reg [1:0] seq_cnt;
	wire [3:0] req = phrase_req_i | seq_req_i;
	// plain phrases ask for no sequencing entry; in sequencing mode the list is
	// a 20 ms gap, a second short phrase, then the end entry
	assign hdr_seq_o = seq_mode_i;
	assign hdr_algo_o = 2'h3;
	assign hdr_gap_ms_o = 11'd20;
	assign hdr_end_o = seq_mode_i ? 24'h00207F : 24'h0FFFFF;
	// the start field is junk outside a header so a stale value never passes
	assign hdr_start_o = !hdr_valid_o ? 24'hFFFFFF : bad_start_i ? 24'h002000 : 24'h002060;
	assign data_o = (data_valid_o != 4'h0) ? {4{16'h4000}} : {4{16'hBFFF}};
	// lowest waiting channel first; the wait restarts after each header
	always @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wait_cnt <= 2'h0;
			tog <= 1'b0;
			hdr_valid_o <= 1'b0;
			hdr_chan_o <= 2'h0;
			hdr_kind_o <= 2'h0;
			seq_cnt <= 2'h0;
			data_valid_o <= 4'h0;
		end else begin
			tog <= !tog;
			data_valid_o <= data_req_i & {4{tog}};
			hdr_valid_o <= 1'b0;
			if (req == 4'h0 || hdr_valid_o)
				wait_cnt <= 2'h0;
			else if (wait_cnt != 2'h3)
				wait_cnt <= wait_cnt + 2'h1;
			else begin
				hdr_valid_o <= 1'b1;
				hdr_chan_o <= req[0] ? 2'h0 : req[1] ? 2'h1 : req[2] ? 2'h2 : 2'h3;
				hdr_kind_o <= (seq_req_i == 4'h0) ? 2'h0 : (seq_cnt == 2'h0) ? 2'h1 :
					(seq_cnt == 2'h1) ? 2'h0 : 2'h2;
				if (seq_req_i != 4'h0)
					seq_cnt <= (seq_cnt == 2'h2) ? 2'h0 : seq_cnt + 2'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
/*
 * Self-checking bench: host byte commands, power state, playback of two
 * channels into the mix stream, and a rejected phrase. Drives 1 ns after edges.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam CMD = 8;
	localparam MS = 10;
	reg clk = 1'b0;
	reg reset_n = 1'b0;
	reg cmd_valid = 1'b0;
	reg tick = 1'b0;
	reg mix_ready = 1'b0;
	reg bad_start = 1'b0;
	reg seq_mode = 1'b0;
	reg [7:0] cmd_byte = 8'h00;
	wire cmd_ready, busy_pin, h_valid, h_seq, m_valid, amp, neg_oe, pos_gnd, sg_gnd, reg_gnd;
	wire [3:0] rdy_n, bsy_n, ph_req, d_req, d_valid, sq_req;
	wire [1:0] h_chan, h_kind, h_algo, pstate;
	wire [23:0] h_start, h_end;
	wire [10:0] h_gap;
	wire [95:0] ent;
	wire [63:0] d_data;
	wire [15:0] m_data;
	integer bad_count = 0;
	integer compares = 0;
	integer cyc = 0;
	voice_playback_power_command_control #(.MS_CYCLES(MS), .CMD_CYCLES(CMD)) i_dut (
		.ref_clk_i(clk), .reset_n_i(reset_n), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_byte_i(cmd_byte), .cmd_busy_pin_n_o(busy_pin),
		.cmd_ready_n_o(rdy_n), .chan_busy_n_o(bsy_n), .phrase_req_o(ph_req),
		.phrase_entry_addr_o(ent), .seq_req_o(sq_req), .hdr_valid_i(h_valid), .hdr_chan_i(h_chan),
		.hdr_kind_i(h_kind), .hdr_algo_i(h_algo), .hdr_start_i(h_start), .hdr_end_i(h_end),
		.hdr_seq_i(h_seq), .hdr_gap_ms_i(h_gap), .data_req_o(d_req), .data_valid_i(d_valid),
		.data_i(d_data), .sample_tick_i(tick), .mix_valid_o(m_valid), .mix_ready_i(mix_ready),
		.mix_data_o(m_data), .speaker_amp_en_o(amp), .speaker_out_neg_oe_o(neg_oe),
		.speaker_out_pos_gnd_o(pos_gnd), .signal_ground_ref_gnd_o(sg_gnd),
		.internal_regulator_out_gnd_o(reg_gnd), .power_state_o(pstate));
	rom_reader_model i_rom (
		.ref_clk_i(clk), .reset_n_i(reset_n), .bad_start_i(bad_start), .phrase_req_i(ph_req),
		.seq_mode_i(seq_mode), .seq_req_i(sq_req),
		.data_req_i(d_req), .hdr_valid_o(h_valid), .hdr_chan_o(h_chan), .hdr_kind_o(h_kind),
		.hdr_algo_o(h_algo), .hdr_start_o(h_start), .hdr_end_o(h_end), .hdr_seq_o(h_seq),
		.hdr_gap_ms_o(h_gap), .data_valid_o(d_valid), .data_o(d_data));
	initial begin
		forever #5 clk = ~clk;
	end
	task end_of_test;
		begin
			$display("compares %0d bad_count %0d", compares, bad_count);
			if (bad_count == 0 && compares > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			end_of_test;
		end
	end
	task chk(input [47:0] got, input [47:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tck;
		begin
			@(posedge clk);
			#1;
		end
	endtask
	task wait_rdy;
		begin
			while (cmd_ready !== 1'b1)
				tck;
		end
	endtask
	// one byte per processing interval; valid drops right after the take
	task send(input [7:0] b);
		begin
			wait_rdy;
			cmd_valid = 1'b1;
			cmd_byte = b;
			tck;
			cmd_valid = 1'b0;
		end
	endtask
	task t_down_ignore;
		begin
			send(8'h20);
			send(8'h04);
			send(8'h02);
			wait_rdy;
			chk({pstate, amp}, 3'h0);
		end
	endtask
	task t_power_up;
		integer n;
		begin
			send(8'h00);
			chk(pstate, 2'h1);
			n = 0;
			while (cmd_ready !== 1'b1) begin
				tck;
				n = n + 1;
			end
			chk(n, CMD);
			chk(amp, 1'b0);
			send(8'h00);
			wait_rdy;
			chk(pstate, 2'h1);
		end
	endtask
	task t_analog_mode_cmd_down;
		begin
			send(8'h04);
			send(8'h02);
			wait_rdy;
			tck;
			chk(amp, 1'b1);
			send(8'h20);
			chk(pstate, 2'h2);
			chk({amp, neg_oe}, 2'h3);
			wait_rdy;
			tck;
			tck;
			chk({pstate, amp, neg_oe, pos_gnd, sg_gnd, reg_gnd}, 7'h07);
			send(8'h00);
			wait_rdy;
			tck;
			tck;
			chk(amp, 1'b0);
		end
	endtask
	task t_mix;
		integer i;
		integer n;
		begin
			// volumes keep the two-channel sum below clipping
			send(8'hA3);
			send(8'h1F);
			send(8'h40);
			send(8'h01);
			send(8'h41);
			send(8'h01);
			wait_rdy;
			chk(ent[47:0], 48'h000008000008);
			chk({rdy_n, bsy_n}, 8'hFC);
			chk(sq_req, 4'h0);
			send(8'h20);
			wait_rdy;
			chk(pstate, 2'h1);
			chk(m_valid, 1'b0);
			// three ticks into a stalled buffer: two stored, one pending
			tick = 1'b1;
			repeat (3) tck;
			tick = 1'b0;
			repeat (3) tck;
			chk(m_valid, 1'b1);
			mix_ready = 1'b1;
			n = 0;
			for (i = 0; i < 8; i = i + 1) begin
				if (m_valid === 1'b1) begin
					chk(m_data, 16'h7C00);
					n = n + 1;
				end
				tck;
			end
			mix_ready = 1'b0;
			chk(n, 3);
			send(8'h63);
			wait_rdy;
			chk(bsy_n, 4'hF);
		end
	endtask
	task t_bad_start;
		begin
			bad_start = 1'b1;
			send(8'h42);
			send(8'h05);
			wait_rdy;
			chk(ent[71:48], 24'h000028);
			chk({rdy_n, bsy_n}, 8'hFF);
			bad_start = 1'b0;
		end
	endtask
	// a phrase that asks for sequencing: gap, a second phrase, then the end entry
	task t_sequence;
		integer n;
		begin
			seq_mode = 1'b1;
			send(8'h40);
			send(8'h02);
			while (sq_req[0] !== 1'b1)
				tck;
			while (sq_req[0] !== 1'b0)
				tck;
			chk(bsy_n[0], 1'b0);
			n = 0;
			while (sq_req[0] !== 1'b1) begin
				tck;
				n = n + 1;
			end
			chk(n, 20 * MS);
			while (sq_req[0] !== 1'b0)
				tck;
			chk(d_req[0], 1'b1);
			while (bsy_n[0] !== 1'b1)
				tck;
			chk({sq_req, rdy_n, bsy_n}, 12'h0FF);
			seq_mode = 1'b0;
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		#1;
		chk({pstate, amp, neg_oe, pos_gnd, sg_gnd, reg_gnd, cmd_ready}, 8'h0F);
		chk({rdy_n, bsy_n, m_valid}, 9'h1FE);
		reset_n = 1'b1;
		t_down_ignore;
		t_power_up;
		t_analog_mode_cmd_down;
		t_mix;
		t_bad_start;
		t_sequence;
		end_of_test;
	end
endmodule
`default_nettype wire
